/* pkg/atd_pkg.sv */
// constants for the accumulator transfer decode block
// Function
// - opcode 0000011010 packs B and A into E; one word, one cycle
// - pack-to-E loads E[7:4] from register B
// - pack-to-E loads E[3:0] from the accumulator in the same cycle
// - opcode 1000101000 copies accumulator to port structure control 0
// - opcode 1000101001 copies accumulator to port structure control 1
// - opcode 1000101010 copies accumulator to port structure control 2
package atd_pkg;
  localparam int unsigned OP_W   = 10;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned EXT_W  = 8;
  localparam logic [9:0] PACK_B_ACC_TO_EXT_OP   = 10'h01A;
  localparam logic [9:0] ACC_TO_PORT_STRUCT0_OP = 10'h228;
  localparam logic [9:0] ACC_TO_PORT_STRUCT1_OP = 10'h229;
  localparam logic [9:0] ACC_TO_PORT_STRUCT2_OP = 10'h22A;
  localparam logic [7:0] EXT_RESET  = 8'h00;
  localparam logic [3:0] PSC_RESET  = 4'h0;
  localparam int unsigned EXT_HI_LSB = 4;
  typedef enum logic [2:0] {
    ATD_OP_NONE,
    ATD_OP_PACK,
    ATD_OP_PSC0,
    ATD_OP_PSC1,
    ATD_OP_PSC2
  } atd_op_e;
endpackage : atd_pkg

/* verilog/atd_opcode_match.sv */
// opcode classifier for the four transfer instructions
`timescale 1ns/1ns
module atd_opcode_match
(
  // instruction word
  input  wire logic [9:0]     opcode,
  input  wire logic           op_valid,
  // decoded class
  output atd_pkg::atd_op_e    op_class
);
  wire is_pack = op_valid && (opcode == atd_pkg::PACK_B_ACC_TO_EXT_OP);
  wire is_psc0 = op_valid && (opcode == atd_pkg::ACC_TO_PORT_STRUCT0_OP);
  wire is_psc1 = op_valid && (opcode == atd_pkg::ACC_TO_PORT_STRUCT1_OP);
  wire is_psc2 = op_valid && (opcode == atd_pkg::ACC_TO_PORT_STRUCT2_OP);
  assign op_class = is_pack ? atd_pkg::ATD_OP_PACK :
                    is_psc0 ? atd_pkg::ATD_OP_PSC0 :
                    is_psc1 ? atd_pkg::ATD_OP_PSC1 :
                    is_psc2 ? atd_pkg::ATD_OP_PSC2 : atd_pkg::ATD_OP_NONE;
endmodule : atd_opcode_match

/* verilog/atd_transfer_decode.sv */
// decode and execute of the pack-to-E and port structure transfer instructions
`timescale 1ns/1ns
module atd_transfer_decode
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // fetch path
  input  wire logic [9:0] opcode,
  input  wire logic       op_valid,
  // register file sources
  input  wire logic [3:0] acc,
  input  wire logic [3:0] reg_b,
  // destinations
  output logic [7:0]      reg_e,
  output logic [3:0]      port_struct_ctrl0,
  output logic [3:0]      port_struct_ctrl1,
  output logic [3:0]      port_struct_ctrl2,
  // status to the sequencer
  output logic            op_done,
  output logic            carry_write,
  output logic            skip_next
);
  // ****************************************
  // decode
  // ****************************************
  atd_pkg::atd_op_e op_class;

  atd_opcode_match u_match
  (
    .opcode   (opcode),
    .op_valid (op_valid),
    .op_class (op_class)
  );

  // ****************************************
  // helpers
  // ****************************************
  // the checks compare the full word themselves rather than trust the classifier
  function automatic logic takes_op
  (
    input logic                     en,
    input logic                     valid,
    input logic [atd_pkg::OP_W-1:0] word,
    input logic [atd_pkg::OP_W-1:0] code
  );
    return en && valid && (word == code);
  endfunction : takes_op

  function automatic logic takes_any
  (
    input logic                     en,
    input logic                     valid,
    input logic [atd_pkg::OP_W-1:0] word
  );
    return takes_op(en, valid, word, atd_pkg::PACK_B_ACC_TO_EXT_OP)
        || takes_op(en, valid, word, atd_pkg::ACC_TO_PORT_STRUCT0_OP)
        || takes_op(en, valid, word, atd_pkg::ACC_TO_PORT_STRUCT1_OP)
        || takes_op(en, valid, word, atd_pkg::ACC_TO_PORT_STRUCT2_OP);
  endfunction : takes_any

  // ****************************************
  // write strobes
  // ****************************************
  // at most one strobe is high: the classifier gives one class per word
  wire       wr_e    = clk_en && (op_class == atd_pkg::ATD_OP_PACK);
  wire       wr_p0   = clk_en && (op_class == atd_pkg::ATD_OP_PSC0);
  wire       wr_p1   = clk_en && (op_class == atd_pkg::ATD_OP_PSC1);
  wire       wr_p2   = clk_en && (op_class == atd_pkg::ATD_OP_PSC2);
  wire       any_op  = clk_en && (op_class != atd_pkg::ATD_OP_NONE);

  // ****************************************
  // state
  // ****************************************
  logic [atd_pkg::EXT_W-1:0] ext_reg;
  logic [atd_pkg::NIB_W-1:0] psc0_reg;
  logic [atd_pkg::NIB_W-1:0] psc1_reg;
  logic [atd_pkg::NIB_W-1:0] psc2_reg;
  logic                      done_reg;
  logic                      carry_flag_reg;
  logic                      skip_flag_reg;

  // ****************************************
  // next values
  // ****************************************
  // high nibble from B, low nibble from A, both sampled in one cycle
  wire [atd_pkg::EXT_W-1:0] ext_next        = wr_e ? {reg_b, acc} : ext_reg;
  // each struct register keeps its value unless its own strobe is high
  wire [atd_pkg::NIB_W-1:0] psc0_next       = wr_p0 ? acc : psc0_reg;
  wire [atd_pkg::NIB_W-1:0] psc1_next       = wr_p1 ? acc : psc1_reg;
  wire [atd_pkg::NIB_W-1:0] psc2_next       = wr_p2 ? acc : psc2_reg;
  // done stands for one enabled cycle and drops on an idle or foreign word
  wire                      done_next       = any_op;
  // carry and skip stay quiet, so the sequencer needs no special case for these words
  wire                      carry_flag_next = 1'b0;
  wire                      skip_flag_next  = 1'b0;

  // ****************************************
  // registers
  // ****************************************
  // one enable gates every flop, so a low clk_en freezes the whole block
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_reg        <= atd_pkg::EXT_RESET;
      psc0_reg       <= atd_pkg::PSC_RESET;
      psc1_reg       <= atd_pkg::PSC_RESET;
      psc2_reg       <= atd_pkg::PSC_RESET;
      done_reg       <= 1'b0;
      carry_flag_reg <= 1'b0;
      skip_flag_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_reg        <= ext_next;
      psc0_reg       <= psc0_next;
      psc1_reg       <= psc1_next;
      psc2_reg       <= psc2_next;
      done_reg       <= done_next;
      carry_flag_reg <= carry_flag_next;
      skip_flag_reg  <= skip_flag_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_e             = ext_reg;
  assign port_struct_ctrl0 = psc0_reg;
  assign port_struct_ctrl1 = psc1_reg;
  assign port_struct_ctrl2 = psc2_reg;
  assign op_done           = done_reg;
  assign carry_write       = carry_flag_reg;
  assign skip_next         = skip_flag_reg;

  // ****************************************
  // checks
  // ****************************************
  chk_pack_e_load: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::PACK_B_ACC_TO_EXT_OP)
      |=> reg_e[atd_pkg::EXT_HI_LSB +: atd_pkg::NIB_W] == $past(reg_b))
    else $error("pack high nibble not from B");

  chk_pack_low_nib: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::PACK_B_ACC_TO_EXT_OP)
      |=> reg_e[atd_pkg::NIB_W-1:0] == $past(acc))
    else $error("pack low nibble not from acc");

  chk_psc0_load: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT0_OP)
      |=> port_struct_ctrl0 == $past(acc) && $stable(reg_e))
    else $error("struct0 not loaded");

  chk_psc1_load: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT1_OP)
      |=> port_struct_ctrl1 == $past(acc) && $stable(port_struct_ctrl0))
    else $error("struct1 not loaded");

  chk_psc2_load: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT2_OP)
      |=> port_struct_ctrl2 == $past(acc) && $stable(port_struct_ctrl1))
    else $error("struct2 not loaded");

  chk_only_dest: assert property (@(posedge clk) disable iff (!resetn)
    !takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT0_OP)
      |=> $stable(port_struct_ctrl0))
    else $error("struct0 written without its opcode");

  chk_freeze_en: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(reg_e) && $stable(port_struct_ctrl2) && $stable(op_done))
    else $error("state moved while enable low");

  chk_no_skip: assert property (@(posedge clk) disable iff (!resetn)
    op_done |-> !skip_next && !carry_write)
    else $error("skip or carry asserted");

  chk_stay_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !op_done |-> !skip_next && !carry_write)
    else $error("skip or carry asserted while idle");

  chk_done_taken: assert property (@(posedge clk) disable iff (!resetn)
    takes_any(clk_en, op_valid, opcode)
      |=> op_done)
    else $error("done missing after a taken word");

  chk_done_refused: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && !takes_any(1'b1, op_valid, opcode)
      |=> !op_done)
    else $error("done raised for a foreign word");

  chk_ext_only: assert property (@(posedge clk) disable iff (!resetn)
    !takes_op(clk_en, op_valid, opcode, atd_pkg::PACK_B_ACC_TO_EXT_OP)
      |=> $stable(reg_e))
    else $error("register E written without its opcode");

  chk_psc1_only: assert property (@(posedge clk) disable iff (!resetn)
    !takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT1_OP)
      |=> $stable(port_struct_ctrl1))
    else $error("struct1 written without its opcode");

  chk_psc2_only: assert property (@(posedge clk) disable iff (!resetn)
    !takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT2_OP)
      |=> $stable(port_struct_ctrl2))
    else $error("struct2 written without its opcode");

  chk_freeze_psc: assert property (@(posedge clk) disable iff (!resetn)
    !clk_en
      |=> $stable(port_struct_ctrl0) && $stable(port_struct_ctrl1))
    else $error("struct registers moved while enable low");

  chk_pack_keeps: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::PACK_B_ACC_TO_EXT_OP)
      |=> $stable(port_struct_ctrl0) && $stable(port_struct_ctrl1) && $stable(port_struct_ctrl2))
    else $error("pack touched a struct register");

  chk_psc0_keeps: assert property (@(posedge clk) disable iff (!resetn)
    takes_op(clk_en, op_valid, opcode, atd_pkg::ACC_TO_PORT_STRUCT0_OP)
      |=> $stable(port_struct_ctrl1) && $stable(port_struct_ctrl2))
    else $error("struct0 word touched another struct register");
endmodule : atd_transfer_decode

/* test/tb.sv */
// testbench for the accumulator transfer decode block
`timescale 1ns/1ns
module tb;
  // ****************************************
  // stimulus, instance and checking
  // ****************************************
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       clk_en = 1'b1;
  logic [9:0] opcode = 10'h000;
  logic       op_valid = 1'b0;
  logic [3:0] acc = 4'h0;
  logic [3:0] reg_b = 4'h0;
  logic [7:0] reg_e;
  logic [3:0] psc0, psc1, psc2;
  logic       op_done, carry_write, skip_next;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  always #4 clk = ~clk;
  atd_transfer_decode atd_transfer_decode_inst (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .opcode(opcode), .op_valid(op_valid), .acc(acc), .reg_b(reg_b),
    .reg_e(reg_e), .port_struct_ctrl0(psc0), .port_struct_ctrl1(psc1),
    .port_struct_ctrl2(psc2), .op_done(op_done), .carry_write(carry_write),
    .skip_next(skip_next));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one word per call: driven at a rising edge, taken at the next one, judged at the
  // falling edge after that; valid drops at the taking edge so the word is taken once
  task step(input logic [9:0] c, input logic [3:0] a, input logic [3:0] b, input logic en);
    @(posedge clk);
    opcode   <= c;
    acc      <= a;
    reg_b    <= b;
    clk_en   <= en;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
  endtask : step
  task t_pack;
    step(atd_pkg::PACK_B_ACC_TO_EXT_OP, 4'h5, 4'hA, 1'b1);
    check("reg_e", reg_e, 8'hA5);
    check("done", op_done, 1'b1);
    check("carry", carry_write | skip_next, 1'b0);
    check("psc0", psc0, 4'h0);
    @(negedge clk);
    check("done", op_done, 1'b0);
  endtask : t_pack
  task t_struct;
    // one word per step, with an idle edge between
    step(atd_pkg::ACC_TO_PORT_STRUCT0_OP, 4'h3, 4'hF, 1'b1);
    check("psc0", psc0, 4'h3);
    check("psc1", psc1, 4'h0);
    step(atd_pkg::ACC_TO_PORT_STRUCT1_OP, 4'h6, 4'hF, 1'b1);
    check("psc1", psc1, 4'h6);
    check("psc2", psc2, 4'h0);
    step(atd_pkg::ACC_TO_PORT_STRUCT2_OP, 4'h9, 4'hF, 1'b1);
    check("psc2", psc2, 4'h9);
    check("done", op_done, 1'b1);
    check("carry", carry_write | skip_next, 1'b0);
    check("others", {psc0, psc1}, 8'h36);
    check("reg_e", reg_e, 8'hA5);
  endtask : t_struct
  task t_refuse;
    // neighbouring opcode outside this block is ignored
    step(10'h22B, 4'hC, 4'hC, 1'b1);
    check("done", op_done, 1'b0);
    check("regs", {psc0, psc1, psc2, reg_e}, 20'h3_69A5);
    step(atd_pkg::PACK_B_ACC_TO_EXT_OP, 4'h1, 4'h2, 1'b0);
    check("frozen", {reg_e, op_done}, 9'h14A);
    step(atd_pkg::PACK_B_ACC_TO_EXT_OP, 4'h1, 4'h2, 1'b1);
    check("reg_e", reg_e, 8'h21);
  endtask : t_refuse
  task t_burst;
    // three words on three edges in a row, none idle between
    @(posedge clk);
    opcode   <= atd_pkg::ACC_TO_PORT_STRUCT2_OP;
    acc      <= 4'h4;
    op_valid <= 1'b1;
    @(posedge clk);
    opcode   <= atd_pkg::ACC_TO_PORT_STRUCT0_OP;
    acc      <= 4'h7;
    @(posedge clk);
    opcode   <= atd_pkg::PACK_B_ACC_TO_EXT_OP;
    acc      <= 4'hE;
    reg_b    <= 4'hB;
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
    check("burst", {psc0, psc1, psc2, reg_e}, 20'h7_64BE);
    check("done", op_done, 1'b1);
  endtask : t_burst
  task t_reset;
    // mid-run reset clears every destination; the first word follows at the next edge
    @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    check("in reset", {reg_e, psc0, psc1, psc2, op_done}, 21'h00_0000);
    @(posedge clk);
    resetn <= 1'b1;
    step(atd_pkg::ACC_TO_PORT_STRUCT1_OP, 4'hD, 4'h0, 1'b1);
    check("psc1", psc1, 4'hD);
    check("others", {psc0, psc2, reg_e}, 16'h0000);
    check("carry", carry_write | skip_next, 1'b0);
  endtask : t_reset
  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check("reset", {reg_e, psc0, psc1, psc2, op_done, carry_write, skip_next}, 23'h00_0000);
    t_pack();
    t_struct();
    t_refuse();
    t_burst();
    t_reset();
    test_done();
  end
endmodule : tb
